// >>> hw/pcg_top.sv
// run, sleep and deep-sleep clock gating for the general-purpose port modules
`timescale 1ns/1ps
`default_nettype none
module pcg_top
  import pcg_pkg::*;
#(
  parameter int NPORTS = PCG_NPORTS
) (
  // clock, reset and freeze
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // processor power state
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  // accesses aimed at port modules
  input wire pcg_access_t port_access,
  output logic port_bus_fault,
  // port clocks
  output logic [NPORTS-1:0] port_clk_en,
  output logic [NPORTS-1:0] port_gclk,
  // interrupt
  output logic irq
);
  // the five-bit layout is fixed; more ports would collide with reserved bits
  if (NPORTS < 1 || NPORTS > PCG_PORT_E_BIT + 1) begin : g_bad_nports
    $error("pcg_top: NPORTS must be 1 to 5");
  end

  typedef struct packed {
    logic [NPORTS-1:0] run_port_clock_enables;
    logic [NPORTS-1:0] sleep_port_clock_enables;
    logic [NPORTS-1:0] deep_sleep_port_clock_enables;
    logic auto_sleep_gating_select;
    logic [NPORTS-1:0] fault_status;
    logic [NPORTS-1:0] fault_mask;
    logic [NPORTS-1:0] active;
    pcg_aphase_t aph;
    logic [31:0] rdata;
    logic ready;
    logic irq;
  } pcg_state_t;

  pcg_state_t state;
  pcg_state_t next_state;
  pcg_mode_t mode;
  logic [NPORTS-1:0] governing;
  logic [NPORTS-1:0] fault_event;
  logic bus_fault;
  logic addr_valid;
  logic [PCG_ADDR_W-1:0] rd_addr;
  logic rd_status;
  logic [NPORTS-1:0] wr_ports;

  // power mode seen by the gating; deep sleep outranks sleep
  always_comb begin
    if (deep_sleep_req) begin
      mode = PCG_MODE_DEEP;
    end else if (sleep_req) begin
      mode = PCG_MODE_SLEEP;
    end else begin
      mode = PCG_MODE_RUN;
    end
  end

  // pick the register that governs the present mode
  always_comb begin
    governing = state.run_port_clock_enables;
    if (state.auto_sleep_gating_select) begin
      unique case (mode)
        PCG_MODE_RUN: governing = state.run_port_clock_enables;
        PCG_MODE_SLEEP: governing = state.sleep_port_clock_enables;
        PCG_MODE_DEEP: governing = state.deep_sleep_port_clock_enables;
      endcase
    end
  end

  // bus address phase decode; only the low offset bits select a register
  assign addr_valid = hsel && hready && (htrans == PCG_HTRANS_NONSEQ || htrans == PCG_HTRANS_SEQ);
  assign rd_addr = haddr[PCG_ADDR_W-1:0];
  assign rd_status = addr_valid && !hwrite && (rd_addr == PCG_STATUS_OFS);
  assign wr_ports = hwdata[NPORTS-1:0];

  // register update, read data and interrupt
  always_comb begin
    next_state = state;
    if (ce) begin
      next_state.ready = 1'b1;
      // write data phase: only the port bits are stored
      if (state.aph.wr_pend) begin
        unique case (state.aph.addr)
          PCG_RUN_OFS: next_state.run_port_clock_enables = wr_ports;
          PCG_SLEEP_OFS: next_state.sleep_port_clock_enables = wr_ports;
          PCG_DEEP_OFS: next_state.deep_sleep_port_clock_enables = wr_ports;
          PCG_CFG_OFS: next_state.auto_sleep_gating_select = hwdata[PCG_AUTO_GATE_BIT];
          PCG_MASK_OFS: next_state.fault_mask = wr_ports;
          default: ;
        endcase
      end
      next_state.aph.wr_pend = addr_valid && hwrite;
      next_state.aph.addr = rd_addr;
      // enables follow the governing register one cycle later
      next_state.active = governing;
      // a read of status clears it, but a fault in the same cycle still lands
      if (rd_status) begin
        next_state.fault_status = '0;
      end
      next_state.fault_status = next_state.fault_status | fault_event;
      // read data from the post-write values so a read right after a write sees it
      next_state.rdata = '0;
      if (addr_valid && !hwrite) begin
        unique case (rd_addr)
          PCG_RUN_OFS: next_state.rdata[NPORTS-1:0] = next_state.run_port_clock_enables;
          PCG_SLEEP_OFS: next_state.rdata[NPORTS-1:0] = next_state.sleep_port_clock_enables;
          PCG_DEEP_OFS: next_state.rdata[NPORTS-1:0] = next_state.deep_sleep_port_clock_enables;
          PCG_CFG_OFS: next_state.rdata[PCG_AUTO_GATE_BIT] = next_state.auto_sleep_gating_select;
          PCG_STATUS_OFS: next_state.rdata[NPORTS-1:0] = state.fault_status | fault_event;
          PCG_MASK_OFS: next_state.rdata[NPORTS-1:0] = next_state.fault_mask;
          PCG_ACTIVE_OFS: next_state.rdata[NPORTS-1:0] = state.active;
          default: ; // unmapped offsets read zero with an okay answer
        endcase
      end
      next_state.irq = |(next_state.fault_status & next_state.fault_mask);
    end
  end

  // reset leaves every port unclocked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // accesses to a port whose clock is off fault
  pcg_fault_check #(
    .NPORTS(NPORTS)
  ) u_fault (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .port_en(state.active),
    .access(port_access),
    .fault(bus_fault),
    .fault_event(fault_event)
  );

  // one gate per port; a clear bit stops the clock entirely, set bit passes it
  for (genvar i = 0; i < NPORTS; i++) begin : g_gate
    pcg_clock_gate u_gate (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .en(state.active[i]),
      .gclk(port_gclk[i])
    );
  end

  assign port_clk_en = state.active;
  assign port_bus_fault = bus_fault;
  assign hreadyout = state.ready;
  assign hresp = 1'b0;
  assign hrdata = state.rdata;
  assign irq = state.irq;
endmodule
`default_nettype wire

// >>> hw/pcg_pkg.sv
// package: register map, field layout and state types of the port clock gating block
package pcg_pkg;
  // register byte offsets from the system control base
  localparam logic [11:0] PCG_RUN_OFS = 12'h108;
  localparam logic [11:0] PCG_SLEEP_OFS = 12'h118;
  localparam logic [11:0] PCG_DEEP_OFS = 12'h128;
  localparam logic [11:0] PCG_CFG_OFS = 12'h060;
  localparam logic [11:0] PCG_STATUS_OFS = 12'h200;
  localparam logic [11:0] PCG_MASK_OFS = 12'h204;
  localparam logic [11:0] PCG_ACTIVE_OFS = 12'h208;
  localparam logic [31:0] PCG_SYSCTL_BASE = 32'h400FE000;
  // field layout
  localparam int PCG_NPORTS = 5;
  localparam int PCG_PORT_A_BIT = 0;
  localparam int PCG_PORT_E_BIT = 4;
  localparam int PCG_AUTO_GATE_BIT = 0;
  localparam int PCG_ADDR_W = 12;
  // reset values
  localparam logic [PCG_NPORTS-1:0] PCG_ENABLES_RST = 5'h00;
  localparam logic PCG_AUTO_GATE_RST = 1'b0;
  // ahb encodings
  localparam logic [1:0] PCG_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PCG_HTRANS_SEQ = 2'h3;

  typedef enum logic [1:0] {PCG_MODE_RUN, PCG_MODE_SLEEP, PCG_MODE_DEEP} pcg_mode_t;

  // one access aimed at a downstream port module
  typedef struct packed {
    logic valid;
    logic [2:0] port;
  } pcg_access_t;

  // ahb address phase as held into the data phase
  typedef struct packed {
    logic wr_pend;
    logic [PCG_ADDR_W-1:0] addr;
  } pcg_aphase_t;
endpackage

// >>> hw/pcg_clock_gate.sv
// glitch-free clock gate for one port module
`timescale 1ns/1ps
`default_nettype none
module pcg_clock_gate
  import pcg_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // control
  input wire logic en,
  // gated clock
  output logic gclk
);
  typedef struct packed {
    logic en_low;
  } pcg_gate_state_t;

  pcg_gate_state_t state;
  pcg_gate_state_t next_state;

  // enable only moves while the clock is low, so the and gate never clips a high phase
  always_comb begin
    next_state = state;
    if (ce) begin
      next_state.en_low = en;
    end
  end

  always_ff @(negedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign gclk = hclk & state.en_low;
endmodule
`default_nettype wire

// >>> hw/pcg_fault_check.sv
// bus fault detection for accesses to unclocked port modules
`timescale 1ns/1ps
`default_nettype none
module pcg_fault_check
  import pcg_pkg::*;
#(
  parameter int NPORTS = PCG_NPORTS
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // port state and incoming access
  input wire logic [NPORTS-1:0] port_en,
  input wire pcg_access_t access,
  // fault answer
  output logic fault,
  output logic [NPORTS-1:0] fault_event
);
  typedef struct packed {
    logic fault;
    logic [NPORTS-1:0] fault_event;
  } pcg_fault_state_t;

  pcg_fault_state_t state;
  pcg_fault_state_t next_state;
  logic [NPORTS-1:0] hit;

  // one-hot target; an index past the last port never faults
  always_comb begin
    hit = '0;
    if (access.valid && (int'(access.port) < NPORTS)) begin
      hit[access.port] = 1'b1;
    end
  end

  // fault is a one-cycle pulse the cycle after an access to a gated port
  always_comb begin
    next_state = state;
    if (ce) begin
      next_state.fault_event = hit & ~port_en;
      next_state.fault = |(hit & ~port_en);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign fault = state.fault;
  assign fault_event = state.fault_event;
endmodule
`default_nettype wire

// >>> bench/pcg_port_model.sv
// model of the processor side that aims accesses at the port modules
`timescale 1ns/1ps
`default_nettype none
module pcg_port_model
  import pcg_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // request from the bench
  input wire logic req,
  input wire logic [2:0] req_port,
  // access toward the gating block
  output var pcg_access_t access
);
  // one cycle per access; the idle index toggles so a stale one is never mistaken for live
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      access <= '0;
    end else begin
      access.valid <= req;
      access.port <= req ? req_port : ~access.port;
    end
  end
endmodule
`default_nettype wire

// >>> bench/pcg_top_sva.sv
// assertions on the ports of the port clock gating block
`timescale 1ns/1ps
`default_nettype none
module pcg_top_sva
  import pcg_pkg::*;
#(
  parameter int NPORTS = PCG_NPORTS
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // bus answer
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  // port side
  input wire pcg_access_t port_access,
  input wire logic port_bus_fault,
  input wire logic [NPORTS-1:0] port_clk_en,
  input wire logic [NPORTS-1:0] port_gclk
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // an access that the block takes this edge
  wire logic take = ce && port_access.valid;
  AST_FAULT_OFF: assert property (take && port_access.port < 3'h5 && !port_clk_en[port_access.port] |=> port_bus_fault)
    else $error("no fault on access to unclocked port");
  AST_FAULT_ON: assert property (take && port_access.port < 3'h5 && port_clk_en[port_access.port] |=> !port_bus_fault)
    else $error("fault on access to clocked port");
  AST_FAULT_NONE: assert property (take && port_access.port > 3'h4 |=> !port_bus_fault)
    else $error("fault on index beyond the ports");
  AST_FAULT_CAUSE: assert property (port_bus_fault |-> $past(take))
    else $error("fault without an access");
  AST_RST_CLEAR: assert property ($rose(hresetn) |-> port_clk_en == '0)
    else $error("port enabled straight out of reset");
  // gclk is sampled on the falling edge, where it shows the enable latched one falling edge before
  AST_GCLK: assert property (@(negedge hclk) port_gclk == $past(port_clk_en))
    else $error("gated clocks disagree with enables");
  AST_READY: assert property ($past(hresetn) && $past(ce) |-> hreadyout)
    else $error("register bus stalled");
  AST_HI_ZERO: assert property (hrdata[31:5] == 27'h0)
    else $error("reserved read data not zero");
endmodule
bind pcg_top pcg_top_sva #(.NPORTS(NPORTS)) i_pcg_top_sva (.hclk(hclk), .hresetn(hresetn), .ce(ce),
  .hreadyout(hreadyout), .hrdata(hrdata), .port_access(port_access), .port_bus_fault(port_bus_fault),
  .port_clk_en(port_clk_en), .port_gclk(port_gclk));
`default_nettype wire

// >>> bench/tb_pcg_top.sv
// self-checking bench for the port clock gating block
`timescale 1ns/1ps
`default_nettype none
module tb_pcg_top
  import pcg_pkg::*;
;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic req = 1'h0;
  logic sleep_req = 1'h0;
  logic deep_sleep_req = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] req_port = 3'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq, port_bus_fault;
  logic [31:0] hrdata;
  logic [4:0] port_clk_en, port_gclk;
  pcg_access_t port_access;
  logic [11:0] ofs [3] = '{PCG_RUN_OFS, PCG_SLEEP_OFS, PCG_DEEP_OFS};
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  // 100 MHz clock
  always #5 hclk = ~hclk;
  pcg_top i_pcg_top (.hclk(hclk), .hresetn(hresetn), .ce(1'h1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req), .port_access(port_access),
    .port_bus_fault(port_bus_fault), .port_clk_en(port_clk_en), .port_gclk(port_gclk), .irq(irq));
  pcg_port_model i_pcg_port_model (.hclk(hclk), .hresetn(hresetn), .req(req), .req_port(req_port),
    .access(port_access));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one single transfer; the master never assumes a latency, it waits for hready
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= PCG_SYSCTL_BASE | 32'(a);
    htrans <= PCG_HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb(1'h1, a, d, rd);
  endtask
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'h0, a, 32'h0, rd);
    chk(what, exp, rd);
  endtask
  // one access through the partner; the model launches it at the second edge, the block
  // answers at the third, and the fault pulse stands only until the fourth
  task automatic touch(input logic [2:0] p, input logic en_ok);
    @(posedge hclk);
    req <= 1'h1;
    req_port <= p;
    @(posedge hclk);
    req <= 1'h0;
    @(posedge hclk);
    #1 chk("port_bus_fault", {31'h0, p < 3'h5 && !en_ok}, {31'h0, port_bus_fault});
  endtask
  function automatic logic [4:0] exp_en(input logic [4:0] run, slp, dp, input logic au, s, d);
    if (!au) return run;
    return d ? dp : (s ? slp : run);
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence: reset values, then random gating and mode mixes
  initial begin
    logic [31:0] v [3];
    logic [4:0] en, st, msk;
    logic au, s, d;
    void'($urandom(98));
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    #1 chk("enables after reset", 32'h0, {27'h0, port_clk_en});
    foreach (ofs[k]) rdchk("gating reset", ofs[k], 32'h0);
    rdchk("unmapped", 12'h30C, 32'h0);
    for (int i = 0; i < 12; i++) begin
      msk = 5'($urandom);
      wr(PCG_MASK_OFS, {27'h0, msk});
      foreach (v[k]) begin
        v[k] = (i == 0) ? 32'hFFFFFFFF : $urandom;
        wr(ofs[k], v[k]);
      end
      au = i[2];
      s = (i % 3) == 1;
      d = (i % 3) == 2;
      wr(PCG_CFG_OFS, {31'h0, au});
      sleep_req <= s;
      deep_sleep_req <= d;
      repeat (3) @(posedge hclk);
      en = exp_en(v[0][4:0], v[1][4:0], v[2][4:0], au, s, d);
      #1 chk("port_clk_en", {27'h0, en}, {27'h0, port_clk_en});
      foreach (v[k]) rdchk("gating readback", ofs[k], {27'h0, v[k][4:0]});
      rdchk("active", PCG_ACTIVE_OFS, {27'h0, en});
      st = 5'h0;
      for (int p = 0; p < 7; p++) begin
        touch(3'(p), p < 5 && en[p]);
        if (p < 5 && !en[p]) st[p] = 1'h1;
      end
      @(posedge hclk);
      #1 chk("irq", {31'h0, |(st & msk)}, {31'h0, irq});
      rdchk("status", PCG_STATUS_OFS, {27'h0, st});
      rdchk("status cleared", PCG_STATUS_OFS, 32'h0);
      #1 chk("irq cleared", 32'h0, {31'h0, irq});
    end
    // a reset in mid-run must drop enables that software had set
    wr(PCG_RUN_OFS, 32'h0000001F);
    wr(PCG_CFG_OFS, 32'h00000000);
    sleep_req <= 1'h0;
    deep_sleep_req <= 1'h0;
    repeat (2) @(posedge hclk);
    #1 chk("enables before reset", 32'h0000001F, {27'h0, port_clk_en});
    @(posedge hclk);
    hresetn <= 1'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    #1 chk("enables after mid reset", 32'h0, {27'h0, port_clk_en});
    foreach (ofs[k]) rdchk("gating mid reset", ofs[k], 32'h0);
    tally_and_finish;
  end
  // hang guard, far above the roughly 740 cycles the run needs
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish;
    end
  end
endmodule
`default_nettype wire
